// [bench/fpl_line_model.sv]
// Behavioural ribbon lines: one actuator module per set bit of the population.
// Assumes the bench changes the population only between checks, index 16*line+address.
`timescale 1ns/1ps
module fpl_line_model
	import fpl_pkg::*;
(
	// Clock
	input  wire logic                        i_clk,
	// Population
	input  wire logic [63:0]                 i_pres,
	input  wire logic [63:0]                 i_dup,
	input  wire logic [63:0]                 i_fault,
	input  wire logic [127:0]                i_cont,
	// Lines
	input  wire fpl_ln_drv_t [FPL_LINES-1:0] i_drv,
	output fpl_ln_rsp_t [FPL_LINES-1:0]      o_rsp
);
	// ==========================================================
	// Idle pattern
	logic       tog = 1'b0;
	logic [5:0] idx;

	// Absent modules leave the contacts floating; a changing pattern keeps
	// a design that ignores the acknowledge from passing by luck
	always @(posedge i_clk) begin
		tog <= ~tog;
	end

	// ==========================================================
	// Answer of the module at the driven address
	always_comb begin
		idx = 6'h00;
		for (int l = 0; l < FPL_LINES; l++) begin
			idx = {2'(l), i_drv[l].addr};
			o_rsp[l].ack = i_pres[idx];
			o_rsp[l].dup = i_pres[idx] & i_dup[idx];
			o_rsp[l].fault = i_pres[idx] & i_fault[idx];
			o_rsp[l].contact = i_pres[idx] ? i_cont[2*idx +: 2] : {tog, ~tog};
		end
	end
endmodule

// [bench/tb_fpl_slave.sv]
// Testbench of the push-button line slave: APB tasks, one task per scenario.
// Assumes the line model answers on all four lines; flash half period shortened.
`timescale 1ns/1ps
module tb_fpl_slave
	import fpl_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int HALF = 20;
	logic                        I_MCLK;
	logic                        I_RST_B;
	logic                        PSEL;
	logic                        PENABLE;
	logic                        PWRITE;
	logic [FPL_AW-1:0]           PADDR;
	logic [31:0]                 PWDATA;
	logic [31:0]                 PRDATA;
	logic                        PREADY;
	logic                        PSLVERR;
	logic [7:0]                  I_ADDR_SW;
	logic                        I_DX_ACTIVE;
	logic [6:0]                  O_SLAVE_ADDR;
	logic                        O_RESTART;
	fpl_ln_rsp_t [FPL_LINES-1:0] I_LN_RSP;
	fpl_ln_drv_t [FPL_LINES-1:0] O_LN_DRV;
	logic                        O_BUS_LED;
	logic                        O_MODULE_ADDRESS_CONFLICT_LED;
	logic                        O_IRQ;
	logic [63:0]                 pres;
	logic [63:0]                 dup;
	logic [63:0]                 fault;
	logic [127:0]                cont;
	int                          errors;
	int                          comparisons;

	fpl_slave #(.FLASH_HALF_CYC(HALF)) i_fpl_slave (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .I_ADDR_SW(I_ADDR_SW),
		.I_DX_ACTIVE(I_DX_ACTIVE), .O_SLAVE_ADDR(O_SLAVE_ADDR), .O_RESTART(O_RESTART),
		.I_LN_RSP(I_LN_RSP), .O_LN_DRV(O_LN_DRV), .O_BUS_LED(O_BUS_LED),
		.O_MODULE_ADDRESS_CONFLICT_LED(O_MODULE_ADDRESS_CONFLICT_LED), .O_IRQ(O_IRQ));
	fpl_line_model i_fpl_line_model (.i_clk(I_MCLK), .i_pres(pres), .i_dup(dup),
		.i_fault(fault), .i_cont(cont), .i_drv(O_LN_DRV), .o_rsp(I_LN_RSP));

	// ==========================================================
	// Common tasks
	task automatic wrap_up();
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic fail_wait(input string what);
		errors++;
		$display("MISMATCH %s expected done seen timeout", what);
		wrap_up();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge I_MCLK);
	endtask
	// Called right after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge I_MCLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (n >= 16) fail_wait("pready");
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge I_MCLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
			input logic [31:0] m);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(what, exp, rd & m);
	endtask
	task automatic lamp_at(input int l, input logic [3:0] a, input logic exp);
		int n;
		n = 0;
		while (O_LN_DRV[l].addr !== a && n < 2000) begin
			@(posedge I_MCLK);
			n++;
		end
		if (n >= 2000) fail_wait("line address");
		tick(2);
		chk("lamp", 32'(exp), 32'(O_LN_DRV[l].lamp));
	endtask
	// Counts exact matches, so an unknown lamp never passes as off
	task automatic lamp_cnt(input int l, input int c, input logic v, output int cnt);
		cnt = 0;
		repeat (c) begin
			@(posedge I_MCLK);
			cnt += int'(O_LN_DRV[l].lamp === v);
		end
	endtask
	task automatic led_edge(output int n);
		logic prev;
		prev = O_BUS_LED;
		n = 0;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (O_BUS_LED === prev && n < 60);
		if (n >= 60) fail_wait("bus led");
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("drive in reset", 32'h0, 32'(O_LN_DRV));
		chk("bus led in reset", 32'h0, 32'(O_BUS_LED));
		I_RST_B <= 1'b1;
		tick(2);
		rdchk("lamp reg", 12'h020, 32'h0, 32'hFFFF);
	endtask
	task automatic t_addr();
		logic [7:0] sw [4] = '{8'h83, 8'h03, 8'hFF, 8'h03};
		logic [6:0] ea [4] = '{7'h03, 7'h03, 7'h7F, 7'h03};
		int         er [4] = '{1, 0, 1, 1};
		int         p;
		for (int i = 0; i < 4; i++) begin
			I_ADDR_SW <= sw[i];
			p = 0;
			repeat (6) begin
				@(posedge I_MCLK);
				p += int'(O_RESTART !== 1'b0);
			end
			chk("restart pulses", 32'(er[i]), 32'(p));
			chk("slave addr", 32'(ea[i]), 32'(O_SLAVE_ADDR));
		end
		rdchk("status addr", FPL_OFS_STATUS, 32'h03, 32'h7F);
	endtask
	task automatic t_lamps();
		wr(12'h024, 32'h0000_0005);
		rdchk("lamp reg", 12'h024, 32'h5, 32'hFFFF);
		lamp_at(1, 4'h2, 1'b1);
		lamp_at(1, 4'h3, 1'b0);
		lamp_at(1, 4'h0, 1'b1);
	endtask
	task automatic t_inputs();
		pres[35] <= 1'b1;
		cont[71:70] <= 2'b10;
		tick(1700);
		rdchk("in line2", 12'h038, 32'h0000_0080, 32'hFFFF_FFFF);
		rdchk("present line2", 12'h058, 32'h0000_0008, 32'hFFFF);
		rdchk("in line1", 12'h034, 32'h0, 32'hFFFF_FFFF);
		rdchk("int events", FPL_OFS_INT_STAT, 32'hE, 32'hE);
	endtask
	task automatic t_lamptest();
		int c;
		wr(12'h040, 32'h0000_0020);
		pres[5] <= 1'b1;
		cont[11:10] <= 2'b01;
		tick(1700);
		rdchk("lamp test", FPL_OFS_CTRL, 32'h1, 32'h1);
		lamp_cnt(3, 200, 1'b1, c);
		chk("lamps forced", 32'd200, 32'(c));
		cont[10] <= 1'b0;
		tick(1700);
		lamp_cnt(3, 200, 1'b0, c);
		chk("lamps released", 32'd200, 32'(c));
	endtask
	task automatic t_conflict();
		wr(FPL_OFS_INT_CLR, 32'h0000_000F);
		wr(FPL_OFS_INT_EN, 32'h0000_0001);
		pres[55] <= 1'b1;
		dup[55] <= 1'b1;
		tick(1700);
		chk("conflict led", 32'h1, 32'(O_MODULE_ADDRESS_CONFLICT_LED));
		chk("irq", 32'h1, 32'(O_IRQ));
		rdchk("dup map", 12'h06C, 32'h0080, 32'hFFFF);
		rdchk("int stat", FPL_OFS_INT_STAT, 32'h1, 32'h1);
		wr(FPL_OFS_INT_EN, 32'h0);
		tick(2);
		chk("irq masked", 32'h0, 32'(O_IRQ));
		wr(FPL_OFS_INT_CLR, 32'h1);
		rdchk("int stat", FPL_OFS_INT_STAT, 32'h0, 32'h1);
		dup[55] <= 1'b0;
		tick(1700);
		chk("conflict off", 32'h0, 32'(O_MODULE_ADDRESS_CONFLICT_LED));
		pres[20] <= 1'b1;
		fault[20] <= 1'b1;
		tick(1700);
		chk("defect led", 32'h1, 32'(O_MODULE_ADDRESS_CONFLICT_LED));
		rdchk("fault map", 12'h064, 32'h0010_0000, 32'hFFFF_0000);
		fault[20] <= 1'b0;
		tick(1700);
		chk("defect off", 32'h0, 32'(O_MODULE_ADDRESS_CONFLICT_LED));
	endtask
	task automatic t_led();
		int n;
		led_edge(n);
		led_edge(n);
		chk("flash half", 32'(HALF), 32'(n));
		rdchk("dx state", FPL_OFS_STATUS, 32'h0, 32'h200);
		I_DX_ACTIVE <= 1'b1;
		tick(3);
		n = 0;
		repeat (40) begin
			@(posedge I_MCLK);
			n += int'(O_BUS_LED === 1'b1);
		end
		chk("led steady", 32'd40, 32'(n));
		rdchk("dx state", FPL_OFS_STATUS, 32'h200, 32'h200);
	endtask
	task automatic t_unmapped();
		logic [31:0] rd;
		logic        err;
		apb(1'b0, 12'h0FC, 32'h0, rd, err);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
	endtask

	// ==========================================================
	// Clock and main sequence
	initial begin
		I_MCLK = 1'b0;
		forever #50 I_MCLK = ~I_MCLK;
	end
	initial begin
		errors = 0;
		comparisons = 0;
		I_RST_B = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		I_ADDR_SW = 8'h00;
		I_DX_ACTIVE = 1'b0;
		pres = 64'h0;
		dup = 64'h0;
		fault = 64'h0;
		cont = 128'h0;
		repeat (6) @(posedge I_MCLK);
		t_reset();
		t_addr();
		t_lamps();
		t_inputs();
		t_lamptest();
		t_conflict();
		t_led();
		t_unmapped();
		wrap_up();
	end
endmodule

// [design/fpl_line_scan.sv]
// One ribbon line: walks line addresses 0..15, drives lamps, samples contacts.
// Assumes the module responses are synchronous and stable by the end of a slot.
`timescale 1ns/1ps
module fpl_line_scan
	import fpl_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Control
	input  wire logic        i_restart,
	input  wire logic        i_step,
	input  wire logic [15:0] i_lamp_map,
	// Line
	input  wire fpl_ln_rsp_t i_rsp,
	output fpl_ln_drv_t      o_drv,
	// Image and status
	output logic [31:0]      o_in_img,
	output logic [15:0]      o_present,
	output logic [15:0]      o_dup,
	output logic [15:0]      o_fault,
	output logic             o_evt_in,
	output logic             o_evt_pres
);

	// ==========================================================
	// Scan state
	logic [3:0]  addr_r,  addr_nxt;
	logic        lamp_r,  lamp_nxt;
	logic [31:0] in_r,    in_nxt;
	logic [15:0] pres_r,  pres_nxt;
	logic [15:0] dup_r,   dup_nxt;
	logic [15:0] fault_r, fault_nxt;
	logic        evi_r,   evi_nxt;
	logic        evp_r,   evp_nxt;
	logic [1:0]  cont;

	always_comb begin
		addr_nxt  = addr_r;
		in_nxt    = in_r;
		pres_nxt  = pres_r;
		dup_nxt   = dup_r;
		fault_nxt = fault_r;
		evi_nxt   = 1'b0;
		evp_nxt   = 1'b0;
		cont      = i_rsp.ack ? i_rsp.contact : 2'b00;
		lamp_nxt  = i_lamp_map[addr_r];
		if (i_restart) begin
			addr_nxt  = 4'h0;
			lamp_nxt  = 1'b0;
			in_nxt    = '0;
			pres_nxt  = FPL_RST_MAP;
			dup_nxt   = FPL_RST_MAP;
			fault_nxt = FPL_RST_MAP;
		end else if (i_step) begin
			in_nxt[{addr_r, 1'b0} +: 2] = cont; // RQ3
			pres_nxt[addr_r]  = i_rsp.ack; // RQ10
			// Recomputed on every visit, so a cleared fault drops out on the next pass
			dup_nxt[addr_r]   = i_rsp.dup; // RQ11
			fault_nxt[addr_r] = i_rsp.fault; // RQ13
			evi_nxt = (in_r[{addr_r, 1'b0} +: 2] != cont);
			evp_nxt = (pres_r[addr_r] != i_rsp.ack);
			addr_nxt = addr_r + 4'h1; // RQ17 RQ9
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_r  <= 4'h0;
			lamp_r  <= 1'b0;
			in_r    <= '0;
			pres_r  <= FPL_RST_MAP;
			dup_r   <= FPL_RST_MAP;
			fault_r <= FPL_RST_MAP;
			evi_r   <= 1'b0;
			evp_r   <= 1'b0;
		end else begin
			addr_r  <= addr_nxt;
			lamp_r  <= lamp_nxt;
			in_r    <= in_nxt;
			pres_r  <= pres_nxt;
			dup_r   <= dup_nxt;
			fault_r <= fault_nxt;
			evi_r   <= evi_nxt;
			evp_r   <= evp_nxt;
		end
	end

	assign o_drv.addr = addr_r;
	assign o_drv.lamp = lamp_r;
	assign o_in_img   = in_r;
	assign o_present  = pres_r;
	assign o_dup      = dup_r;
	assign o_fault    = fault_r;
	assign o_evt_in   = evi_r;
	assign o_evt_pres = evp_r;

	// ==========================================================
	// Checks
	property p_scan_step;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_step && !i_restart) |=> (addr_r == $past(addr_r) + 4'h1);
	endproperty
	a_scan_step: assert property (p_scan_step) else $error("line address did not advance"); // RQ17

	property p_pres_sample;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_step && !i_restart) |=> (pres_r[$past(addr_r)] == $past(i_rsp.ack));
	endproperty
	a_pres_sample: assert property (p_pres_sample) else $error("presence not sampled"); // RQ10

	property p_in_sample;
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_step && !i_restart && i_rsp.ack)
			|=> (in_r[{$past(addr_r), 1'b0} +: 2] == $past(i_rsp.contact));
	endproperty
	a_in_sample: assert property (p_in_sample) else $error("contact not in image"); // RQ3

endmodule

// [design/fpl_pkg.sv]
// Constants, register map and carrier types of the push-button line slave.
// Assumes a single 10 MHz clock and an APB register bus with 12 address bits.
package fpl_pkg;

	// ==========================================================
	// Sizes
	localparam int FPL_LINES   = 4;
	localparam int FPL_ADDRS   = 16;
	localparam int FPL_MODULES = 64;
	localparam int FPL_AW      = 12;

	// ==========================================================
	// Timing
	localparam int FPL_CLK_HZ         = 10_000_000;
	localparam int FPL_SLOT_US        = 10;
	localparam int FPL_SLOT_CYC       = (FPL_SLOT_US * FPL_CLK_HZ + 999_999) / 1_000_000;
	localparam int FPL_FLASH_HALF_MS  = 500;
	localparam int FPL_FLASH_HALF_CYC = FPL_FLASH_HALF_MS * (FPL_CLK_HZ / 1000);

	// ==========================================================
	// Register map (byte addresses; bases are PADDR[11:4])
	localparam logic [11:0] FPL_OFS_CTRL     = 12'h000;
	localparam logic [11:0] FPL_OFS_STATUS   = 12'h004;
	localparam logic [11:0] FPL_OFS_INT_STAT = 12'h008;
	localparam logic [11:0] FPL_OFS_INT_EN   = 12'h00C;
	localparam logic [11:0] FPL_OFS_INT_CLR  = 12'h010;
	localparam logic [7:0]  FPL_BASE_LAMP    = 8'h02;
	localparam logic [7:0]  FPL_BASE_IN      = 8'h03;
	localparam logic [7:0]  FPL_BASE_LTEST   = 8'h04;
	localparam logic [7:0]  FPL_BASE_PRES    = 8'h05;
	localparam logic [7:0]  FPL_BASE_DUP     = 8'h06;

	// ==========================================================
	// Interrupt sources
	localparam int FPL_EV_W        = 4;
	localparam int FPL_EV_CONFLICT = 0;
	localparam int FPL_EV_RESTART  = 1;
	localparam int FPL_EV_PRES     = 2;
	localparam int FPL_EV_INPUT    = 3;

	// ==========================================================
	// Reset values
	localparam logic [15:0] FPL_RST_MAP = 16'h0000;
	localparam logic [6:0]  FPL_RST_SA  = 7'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] addr;
		logic       lamp;
	} fpl_ln_drv_t;

	typedef struct packed {
		logic       ack;
		logic       dup;
		logic       fault;
		logic [1:0] contact;
	} fpl_ln_rsp_t;

	typedef enum logic {FPL_ST_WAIT, FPL_ST_DX} fpl_bus_st_t;

endpackage

// [design/fpl_slave.sv]
// Top of the push-button line slave: four scanned lines, APB registers,
// slave address switches, lamp test, indicators and interrupt.
// Assumes the fieldbus protocol engine sits outside and reports data exchange.
// Function
// RQ1 - Up to sixty-four modules, mixed types allowed
// RQ2 - At most four ribbon-cable lines
// RQ3 - Lamps are output bits, contacts input bits
// RQ4 - Lamp-test contact forces every lamp on
// RQ5 - Slave address 0 to 127 from switches
// RQ6 - Address is binary weighted switch sum
// RQ7 - Eighth address switch is ignored
// RQ8 - Restart when switch address changes
// RQ9 - Modules use four-bit line addresses
// RQ10 - Modules are detected automatically
// RQ11 - Lines checked continuously for duplicate addresses
// RQ12 - Conflict indicator on for duplicated address
// RQ13 - Conflict indicator also for defect, else off
// RQ14 - Bus indicator steady in exchange, else flashing
// RQ15 - Installer keeps line addresses unique
// RQ16 - Master uses addresses 1 to 124 matching
// RQ17 - Scan addresses 0..15, flash about 1 s
// RQ18 - Reset clears lamps, bus indicator waits
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module fpl_slave
	import fpl_pkg::*;
#(
	parameter int FLASH_HALF_CYC = FPL_FLASH_HALF_CYC
)(
	// Clock and reset
	input  wire logic                        I_MCLK,
	input  wire logic                        I_RST_B,
	// APB slave
	input  wire logic                        PSEL,
	input  wire logic                        PENABLE,
	input  wire logic                        PWRITE,
	input  wire logic [FPL_AW-1:0]           PADDR,
	input  wire logic [31:0]                 PWDATA,
	output logic [31:0]                      PRDATA,
	output logic                             PREADY,
	output logic                             PSLVERR,
	// Slave address switches and protocol engine
	input  wire logic [7:0]                  I_ADDR_SW,
	input  wire logic                        I_DX_ACTIVE,
	output logic [6:0]                       O_SLAVE_ADDR,
	output logic                             O_RESTART,
	// Ribbon lines
	input  wire fpl_ln_rsp_t [FPL_LINES-1:0] I_LN_RSP,
	output fpl_ln_drv_t [FPL_LINES-1:0]      O_LN_DRV,
	// Indicators and interrupt
	output logic                             O_BUS_LED,
	output logic                             O_MODULE_ADDRESS_CONFLICT_LED,
	output logic                             O_IRQ
);

	// ==========================================================
	// Slave address and restart
	logic [6:0] sa_r, sa_nxt;
	logic       rst_r, rst_nxt;

	always_comb begin
		// Bit 7 carries no weight; bits 6..0 weigh 2**n, so the sum is the field
		sa_nxt  = I_ADDR_SW[6:0]; // RQ5 RQ6 RQ7
		rst_nxt = (I_ADDR_SW[6:0] != sa_r); // RQ8
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sa_r  <= FPL_RST_SA;
			rst_r <= 1'b0;
		end else begin
			sa_r  <= sa_nxt;
			rst_r <= rst_nxt;
		end
	end

	assign O_SLAVE_ADDR = sa_r;
	assign O_RESTART    = rst_r;

	// ==========================================================
	// Slot divider: one step pulse per line slot
	logic [7:0] slot_r, slot_nxt;
	logic       step_r, step_nxt;

	always_comb begin
		slot_nxt = slot_r + 8'h01;
		step_nxt = 1'b0;
		if (rst_r) begin
			slot_nxt = 8'h00;
		end else if (slot_r == 8'(FPL_SLOT_CYC - 1)) begin
			slot_nxt = 8'h00;
			step_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			slot_r <= 8'h00;
			step_r <= 1'b0;
		end else begin
			slot_r <= slot_nxt;
			step_r <= step_nxt;
		end
	end

	// ==========================================================
	// Lines
	logic [FPL_LINES-1:0][15:0] lamp_r, lamp_nxt;
	logic [FPL_LINES-1:0][15:0] ltest_r, ltest_nxt;
	logic [FPL_LINES-1:0][15:0] lamp_map;
	logic [FPL_LINES-1:0][31:0] in_img;
	logic [FPL_LINES-1:0][15:0] present;
	logic [FPL_LINES-1:0][15:0] dup;
	logic [FPL_LINES-1:0][15:0] fault;
	logic [FPL_LINES-1:0]       ev_in;
	logic [FPL_LINES-1:0]       ev_pres;
	logic [FPL_LINES-1:0]       lt_line;
	logic                       ltest_act;

	// 4 lines x 16 addresses gives the 64 module slots
	for (genvar l = 0; l < FPL_LINES; l++) begin : g_line // RQ1 RQ2
		logic [15:0] no0;
		for (genvar a = 0; a < FPL_ADDRS; a++) begin : g_bit
			assign no0[a] = in_img[l][2 * a];
		end
		assign lt_line[l]  = |(no0 & ltest_r[l] & present[l]);
		assign lamp_map[l] = lamp_r[l] | {16{ltest_act}}; // RQ4

		fpl_line_scan u_scan (
			.i_clk      (I_MCLK),
			.i_rst_b    (I_RST_B),
			.i_restart  (rst_r),
			.i_step     (step_r),
			.i_lamp_map (lamp_map[l]),
			.i_rsp      (I_LN_RSP[l]),
			.o_drv      (O_LN_DRV[l]),
			.o_in_img   (in_img[l]),
			.o_present  (present[l]),
			.o_dup      (dup[l]),
			.o_fault    (fault[l]),
			.o_evt_in   (ev_in[l]),
			.o_evt_pres (ev_pres[l])
		);
	end

	assign ltest_act = |lt_line;

	// ==========================================================
	// Conflict indicator
	logic conf_r, conf_nxt;

	always_comb begin
		// Duplicates are not legal on a line, so any hit is shown at once
		conf_nxt = |dup || |fault; // RQ12 RQ13 RQ15
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			conf_r <= 1'b0;
		end else begin
			conf_r <= conf_nxt;
		end
	end

	assign O_MODULE_ADDRESS_CONFLICT_LED = conf_r;

	// ==========================================================
	// Bus status indicator
	fpl_bus_st_t st_r, st_nxt;
	logic [22:0] fcnt_r, fcnt_nxt;
	logic        fl_r, fl_nxt;
	logic        bled_r, bled_nxt;

	always_comb begin
		st_nxt   = st_r;
		fcnt_nxt = fcnt_r + 23'h000001;
		fl_nxt   = fl_r;
		case (st_r)
			FPL_ST_WAIT: begin
				if (I_DX_ACTIVE) begin
					st_nxt = FPL_ST_DX;
				end
			end
			FPL_ST_DX: begin
				if (!I_DX_ACTIVE) begin
					st_nxt = FPL_ST_WAIT;
				end
			end
			default: begin
				st_nxt = FPL_ST_WAIT;
			end
		endcase
		if (fcnt_r == 23'(FLASH_HALF_CYC - 1)) begin
			fcnt_nxt = 23'h000000;
			fl_nxt   = !fl_r; // RQ17
		end
		if (rst_r) begin
			st_nxt   = FPL_ST_WAIT; // RQ18
			fcnt_nxt = 23'h000000;
			fl_nxt   = 1'b0;
		end
		bled_nxt = (st_nxt == FPL_ST_DX) ? 1'b1 : fl_nxt; // RQ14
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st_r   <= FPL_ST_WAIT;
			fcnt_r <= 23'h000000;
			fl_r   <= 1'b0;
			bled_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			fcnt_r <= fcnt_nxt;
			fl_r   <= fl_nxt;
			bled_r <= bled_nxt;
		end
	end

	assign O_BUS_LED = bled_r;

	// ==========================================================
	// APB registers and interrupt
	logic [FPL_EV_W-1:0] ist_r, ist_nxt;
	logic [FPL_EV_W-1:0] ien_r, ien_nxt;
	logic [FPL_EV_W-1:0] ev;
	logic                irq_r, irq_nxt;
	logic [31:0]         rd_r, rd_nxt;
	logic [1:0]          li;
	logic [7:0]          base;
	logic                wr;
	logic                hit;

	assign li   = PADDR[3:2];
	assign base = PADDR[11:4];
	assign wr   = PSEL && PENABLE && PWRITE;

	always_comb begin
		hit = (PADDR[1:0] == 2'b00) &&
			(PADDR == FPL_OFS_CTRL || PADDR == FPL_OFS_STATUS ||
			 PADDR == FPL_OFS_INT_STAT || PADDR == FPL_OFS_INT_EN ||
			 PADDR == FPL_OFS_INT_CLR || base == FPL_BASE_LAMP ||
			 base == FPL_BASE_IN || base == FPL_BASE_LTEST ||
			 base == FPL_BASE_PRES || base == FPL_BASE_DUP);
	end

	always_comb begin
		ev = '0;
		ev[FPL_EV_CONFLICT] = conf_nxt && !conf_r;
		ev[FPL_EV_RESTART]  = rst_r;
		ev[FPL_EV_PRES]     = |ev_pres;
		ev[FPL_EV_INPUT]    = |ev_in;
		lamp_nxt  = lamp_r;
		ltest_nxt = ltest_r;
		ien_nxt   = ien_r;
		ist_nxt   = ist_r;
		if (wr && hit && PADDR == FPL_OFS_INT_CLR) begin
			ist_nxt = ist_r & ~PWDATA[FPL_EV_W-1:0];
		end
		// A new event in the clearing cycle survives the clear
		ist_nxt = ist_nxt | ev;
		if (wr && hit) begin
			if (PADDR == FPL_OFS_INT_EN) begin
				ien_nxt = PWDATA[FPL_EV_W-1:0];
			end
			if (base == FPL_BASE_LAMP) begin
				lamp_nxt[li] = PWDATA[15:0]; // RQ3
			end
			if (base == FPL_BASE_LTEST) begin
				ltest_nxt[li] = PWDATA[15:0];
			end
		end
		if (rst_r) begin
			lamp_nxt = '0; // RQ18
		end
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	always_comb begin
		rd_nxt = rd_r;
		if (PSEL && !PENABLE) begin
			rd_nxt = 32'h00000000;
			if (PADDR == FPL_OFS_CTRL) begin
				rd_nxt = {31'h00000000, ltest_act};
			end else if (PADDR == FPL_OFS_STATUS) begin
				rd_nxt = {22'h000000, st_r == FPL_ST_DX, conf_r, 1'b0, sa_r};
			end else if (PADDR == FPL_OFS_INT_STAT) begin
				rd_nxt[FPL_EV_W-1:0] = ist_r;
			end else if (PADDR == FPL_OFS_INT_EN) begin
				rd_nxt[FPL_EV_W-1:0] = ien_r;
			end else if (base == FPL_BASE_LAMP) begin
				rd_nxt[15:0] = lamp_r[li];
			end else if (base == FPL_BASE_IN) begin
				rd_nxt = in_img[li]; // RQ3
			end else if (base == FPL_BASE_LTEST) begin
				rd_nxt[15:0] = ltest_r[li];
			end else if (base == FPL_BASE_PRES) begin
				rd_nxt[15:0] = present[li];
			end else if (base == FPL_BASE_DUP) begin
				rd_nxt = {fault[li], dup[li]};
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			lamp_r  <= '0;
			ltest_r <= '0;
			ien_r   <= '0;
			ist_r   <= '0;
			irq_r   <= 1'b0;
			rd_r    <= 32'h00000000;
		end else begin
			lamp_r  <= lamp_nxt;
			ltest_r <= ltest_nxt;
			ien_r   <= ien_nxt;
			ist_r   <= ist_nxt;
			irq_r   <= irq_nxt;
			rd_r    <= rd_nxt;
		end
	end

	assign PRDATA  = rd_r;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign O_IRQ   = irq_r;

	// ==========================================================
	// Checks
	property p_lamp_test;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(ltest_act && !rst_r) |=> (O_LN_DRV[0].lamp && O_LN_DRV[1].lamp &&
			O_LN_DRV[2].lamp && O_LN_DRV[3].lamp);
	endproperty
	a_lamp_test: assert property (p_lamp_test) else $error("lamp test not on all lamps"); // RQ4

	property p_sa_follow;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		1'b1 |=> (O_SLAVE_ADDR == $past(I_ADDR_SW[6:0]));
	endproperty
	a_sa_follow: assert property (p_sa_follow) else $error("slave address wrong"); // RQ6

	property p_restart_on_change;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(I_ADDR_SW[6:0] != O_SLAVE_ADDR) |=> O_RESTART ##1 (lamp_r == '0);
	endproperty
	a_restart_on_change: assert property (p_restart_on_change) else $error("no restart"); // RQ8

	property p_sw8_ignored;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(I_ADDR_SW[6:0] == O_SLAVE_ADDR) |=> !O_RESTART;
	endproperty
	a_sw8_ignored: assert property (p_sw8_ignored) else $error("spurious restart"); // RQ7

	property p_conflict_on;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(|dup) |=> O_MODULE_ADDRESS_CONFLICT_LED;
	endproperty
	a_conflict_on: assert property (p_conflict_on) else $error("conflict led not on"); // RQ12

	property p_conflict_off;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(!(|dup) && !(|fault)) |=> !O_MODULE_ADDRESS_CONFLICT_LED;
	endproperty
	a_conflict_off: assert property (p_conflict_off) else $error("conflict led stuck"); // RQ13

	property p_bus_steady;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		(I_DX_ACTIVE && !rst_r) [*2] |=> O_BUS_LED;
	endproperty
	a_bus_steady: assert property (p_bus_steady) else $error("bus led not steady"); // RQ14

	property p_bus_wait;
		@(posedge I_MCLK) disable iff (!I_RST_B)
		rst_r |=> (st_r == FPL_ST_WAIT) && !O_BUS_LED;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus led not waiting"); // RQ18

endmodule
